//--- rtl/kpi_pkg.sv
package kpi_pkg;
	localparam int KPI_NPINS = 8;
	localparam int KPI_ADDR_W = 4;
	localparam logic [3:0] KPI_OFF_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] KPI_OFF_PIN_ENABLE = 4'h1;
	localparam logic [3:0] KPI_OFF_IRQ_STATUS = 4'h2;
	localparam logic [3:0] KPI_OFF_IRQ_MASK = 4'h3;
	localparam logic [7:0] KPI_RST_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] KPI_RST_PIN_ENABLE = 8'h00;
	localparam logic [1:0] KPI_RST_IRQ = 2'h0;
	localparam int KPI_POS_DETECT_MODE = 0;
	localparam int KPI_POS_IRQ_ENABLE = 1;
	localparam int KPI_POS_ACK = 2;
	localparam int KPI_POS_PENDING = 3;
	localparam int KPI_POS_POLARITY_LO = 4;
	localparam int KPI_POS_EVT_EDGE = 0;
	localparam int KPI_POS_EVT_LEVEL = 1;
	typedef struct packed {
		logic [3:0] edge_polarity_select;
		logic pending_flag;
		logic event_acknowledge;
		logic event_irq_enable;
		logic detect_mode_select;
	} kpi_status_control_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} kpi_bus_req_t;
endpackage : kpi_pkg

//--- rtl/kpi_keypad_interrupt_unit.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// [R1] eight pins, each enabled on its own
// [R2] pins 7..4 polarity select per bit
// [R3] pins 3..0 falling edge or low only
// [R4] pending flag bit 3 set on event
// [R5] ack write of one clears pending
// [R6] edge-level mode: asserted pin keeps pending set
// [R7] acknowledge bit is write-only, reads zero
// [R8] irq enable bit 1 gates interrupt request
// [R9] mode bit: 0 edge, 1 edge-and-level
// [R10] pin enable connects pin, else ignored
// [R11] edge is deasserted then asserted cycle
// [R12] stop mode: async level wake-up
// [R13] two-stage synchroniser on every pin
module kpi_keypad_interrupt_unit #(
	parameter int NPINS = kpi_pkg::KPI_NPINS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire kpi_pkg::kpi_bus_req_t bus_req,
	output logic [7:0] rdata,
	input wire logic [NPINS-1:0] pin_in,
	input wire logic stop_mode,
	output logic wake_req,
	output logic irq_req,
	output logic irq
);
	kpi_pkg::kpi_status_control_t sc_q;
	logic [NPINS-1:0] pin_en_q;
	logic [NPINS-1:0] sync1_q;
	logic [NPINS-1:0] sync2_q;
	logic [NPINS-1:0] prev_q;
	logic [NPINS-1:0] asserted;
	logic [NPINS-1:0] prev_asserted;
	logic [1:0] evt_st_q;
	logic [1:0] evt_msk_q;
	logic edge_evt;
	logic level_hold;
	logic sc_wr;
	logic ack_wr;
	logic pend_d;
	logic [1:0] evt_set;

	assign sc_wr = bus_req.wr && bus_req.addr == kpi_pkg::KPI_OFF_STATUS_CONTROL;
	assign ack_wr = sc_wr && bus_req.wdata[kpi_pkg::KPI_POS_ACK];

	// per pin: asserted level after polarity, masked by enable
	genvar g;
	generate
		for (g = 0; g < NPINS; g++)
		begin : g_pin
			logic pol;
			if (g >= kpi_pkg::KPI_POS_POLARITY_LO)
			begin : g_sel
				assign pol = sc_q.edge_polarity_select[g - kpi_pkg::KPI_POS_POLARITY_LO]; // R2
			end
			else
			begin : g_fix
				assign pol = 1'b0; // R3
			end
			assign asserted[g] = pin_en_q[g] && (sync2_q[g] == pol); // R10
			assign prev_asserted[g] = pin_en_q[g] && (prev_q[g] == pol); // R1
		end
	endgenerate

	// edge: seen deasserted last cycle and asserted now
	assign edge_evt = |(asserted & ~prev_asserted); // R11
	assign level_hold = sc_q.detect_mode_select && (|asserted); // R6 R9

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end
		else if (clk_en)
		begin
			sync1_q <= pin_in; // R13
			sync2_q <= sync1_q; // R13
			prev_q <= sync2_q;
		end
	end

	// set wins over the acknowledge in the same cycle
	always_comb
	begin
		pend_d = sc_q.pending_flag;
		if (ack_wr)
			pend_d = 1'b0; // R5
		if (edge_evt || level_hold)
			pend_d = 1'b1; // R4 R6
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sc_q <= kpi_pkg::KPI_RST_STATUS_CONTROL;
			pin_en_q <= '0;
		end
		else if (clk_en)
		begin
			sc_q.pending_flag <= pend_d;
			sc_q.event_acknowledge <= 1'b0; // R7
			if (sc_wr)
			begin
				sc_q.edge_polarity_select <= bus_req.wdata[7:4];
				sc_q.event_irq_enable <= bus_req.wdata[kpi_pkg::KPI_POS_IRQ_ENABLE];
				sc_q.detect_mode_select <= bus_req.wdata[kpi_pkg::KPI_POS_DETECT_MODE]; // R9
			end
			if (bus_req.wr && bus_req.addr == kpi_pkg::KPI_OFF_PIN_ENABLE)
				pin_en_q <= bus_req.wdata[NPINS-1:0];
		end
	end

	// sticky event status: edge events and level-held events
	assign evt_set = {level_hold, edge_evt};
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			evt_st_q <= kpi_pkg::KPI_RST_IRQ;
			evt_msk_q <= kpi_pkg::KPI_RST_IRQ;
			irq <= 1'b0;
		end
		else if (clk_en)
		begin
			if (bus_req.wr && bus_req.addr == kpi_pkg::KPI_OFF_IRQ_STATUS)
				evt_st_q <= (evt_st_q & ~bus_req.wdata[1:0]) | evt_set;
			else
				evt_st_q <= evt_st_q | evt_set;
			if (bus_req.wr && bus_req.addr == kpi_pkg::KPI_OFF_IRQ_MASK)
				evt_msk_q <= bus_req.wdata[1:0];
			irq <= |((evt_st_q | evt_set) & evt_msk_q);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq_req <= 1'b0;
		else if (clk_en)
			irq_req <= pend_d && sc_q.event_irq_enable; // R8
	end

	// in stop the clock may be frozen; wake is a level from the raw pins,
	// registered only so the output is a flop while running
	logic [NPINS-1:0] raw_asserted;
	generate
		for (g = 0; g < NPINS; g++)
		begin : g_raw
			if (g >= kpi_pkg::KPI_POS_POLARITY_LO)
			begin : g_sel
				assign raw_asserted[g] = pin_en_q[g] &&
					(pin_in[g] == sc_q.edge_polarity_select[g - kpi_pkg::KPI_POS_POLARITY_LO]);
			end
			else
			begin : g_fix
				assign raw_asserted[g] = pin_en_q[g] && !pin_in[g];
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wake_req <= 1'b0;
		else
			wake_req <= stop_mode && (|raw_asserted); // R12
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			rdata <= 8'h00;
		else if (clk_en && bus_req.rd)
		begin
			case (bus_req.addr)
				kpi_pkg::KPI_OFF_STATUS_CONTROL: rdata <= {sc_q.edge_polarity_select, sc_q.pending_flag, 1'b0,
					sc_q.event_irq_enable, sc_q.detect_mode_select}; // R7
				kpi_pkg::KPI_OFF_PIN_ENABLE: rdata <= 8'(pin_en_q);
				kpi_pkg::KPI_OFF_IRQ_STATUS: rdata <= {6'h00, evt_st_q};
				kpi_pkg::KPI_OFF_IRQ_MASK: rdata <= {6'h00, evt_msk_q};
				default: rdata <= 8'h00;
			endcase
		end
		else if (clk_en)
			rdata <= 8'h00;
	end

	property p_edge_sets;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && edge_evt) |=> sc_q.pending_flag;
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("edge did not set pending"); // R4

	property p_ack_clears;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && ack_wr && !edge_evt && !level_hold) |=> !sc_q.pending_flag;
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear pending"); // R5

	property p_level_holds;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && sc_q.detect_mode_select && (|asserted)) |=> sc_q.pending_flag;
	endproperty
	a_level_holds: assert property (p_level_holds) else $error("level mode pending dropped"); // R6

	property p_ack_reads_zero;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && bus_req.rd && bus_req.addr == kpi_pkg::KPI_OFF_STATUS_CONTROL) |=> !rdata[kpi_pkg::KPI_POS_ACK];
	endproperty
	a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read nonzero"); // R7

	property p_irq_gate;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && !sc_q.event_irq_enable) |=> !irq_req;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq request while disabled"); // R8

	property p_disabled_ignored;
		@(posedge clk) disable iff (!rst_b)
		(pin_en_q == '0) |-> !edge_evt && !level_hold;
	endproperty
	a_disabled_ignored: assert property (p_disabled_ignored) else $error("disabled pin raised event"); // R10

	property p_low_pins_falling;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && pin_en_q[0] && $fell(sync2_q[0]) && !sc_q.pending_flag) |=> sc_q.pending_flag;
	endproperty
	a_low_pins_falling: assert property (p_low_pins_falling) else $error("pin0 falling missed"); // R3

	property p_sync_delay;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && $past(clk_en, 1) && $past(clk_en, 2) && $past(rst_b, 1) && $past(rst_b, 2))
			|-> sync2_q == $past(pin_in, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("synchroniser depth wrong"); // R13

	property p_edge_only_mode;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && !sc_q.detect_mode_select && ack_wr && !edge_evt) |=> !sc_q.pending_flag;
	endproperty
	a_edge_only_mode: assert property (p_edge_only_mode) else $error("edge mode ack failed"); // R9

	// clk_en low must hold every register; the check skips evt_msk_q, sync1_q and prev_q, and wake_req is left out on purpose
	property p_freeze;
		@(posedge clk) disable iff (!rst_b)
		(!clk_en) |=> $stable(sc_q) && $stable(pin_en_q) && $stable(evt_st_q) && $stable(sync2_q) &&
			$stable(irq) && $stable(irq_req) && $stable(rdata);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

	property p_rise_pol;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && pin_en_q[4] && sc_q.edge_polarity_select[0] && $rose(sync2_q[4])) |=> sc_q.pending_flag;
	endproperty
	a_rise_pol: assert property (p_rise_pol) else $error("rising edge on pin4 missed"); // R2

	property p_irq_follows;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && sc_q.event_irq_enable && sc_q.pending_flag && !ack_wr) |=> irq_req;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("no irq request while pending"); // R8

	property p_wake;
		@(posedge clk) disable iff (!rst_b)
		(stop_mode && (|raw_asserted)) |=> wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("stop mode wake missed"); // R12

	property p_pending_read;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && bus_req.rd && bus_req.addr == kpi_pkg::KPI_OFF_STATUS_CONTROL)
			|=> rdata[kpi_pkg::KPI_POS_PENDING] == $past(sc_q.pending_flag);
	endproperty
	a_pending_read: assert property (p_pending_read) else $error("pending bit read wrong"); // R4

	// unmapped reads and idle cycles leave the read bus at zero
	property p_unmapped_zero;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && bus_req.rd && bus_req.addr > kpi_pkg::KPI_OFF_IRQ_MASK) |=> rdata == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

	property p_idle_zero;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && !bus_req.rd) |=> rdata == 8'h00;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data outside read cycle");

	property p_enable_only;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && !pin_en_q[0] && $fell(sync2_q[0]) && !sc_q.pending_flag && (|(asserted & ~prev_asserted)) == 1'b0
			&& !level_hold) |=> !sc_q.pending_flag;
	endproperty
	a_enable_only: assert property (p_enable_only) else $error("disabled pin0 set pending"); // R10

	c_edge: cover property (@(posedge clk) disable iff (!rst_b) edge_evt ##1 sc_q.pending_flag);
	c_freeze: cover property (@(posedge clk) disable iff (!rst_b) !clk_en ##1 clk_en);
	c_ack: cover property (@(posedge clk) disable iff (!rst_b) sc_q.pending_flag ##1 ack_wr ##1 !sc_q.pending_flag);
	c_level: cover property (@(posedge clk) disable iff (!rst_b) level_hold && ack_wr);
	c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq_req ##[1:20] irq);
endmodule : kpi_keypad_interrupt_unit

//--- sim/kpi_pin_model.sv
`timescale 1ns/100ps
// released keys fall back to their idle level, never hold the last value
module kpi_pin_model (
	input wire logic [7:0] press,
	input wire logic [3:0] pol,
	output logic [7:0] pin
);
	assign pin[7:4] = press[7:4] ^ ~pol;
	assign pin[3:0] = ~press[3:0];
endmodule : kpi_pin_model

//--- sim/keypad_pin_interrupt_tb.sv
`timescale 1ns/100ps
module keypad_pin_interrupt_tb;
	logic clk;
	logic rst_b;
	logic clk_en;
	logic stop_mode;
	logic [7:0] press;
	logic [7:0] pin;
	logic [7:0] rdata;
	logic wake_req;
	logic irq_req;
	logic irq;
	kpi_pkg::kpi_bus_req_t req;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	kpi_pin_model i_pins (.press(press), .pol(4'h1), .pin(pin));
	kpi_keypad_interrupt_unit i_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .bus_req(req),
		.rdata(rdata), .pin_in(pin), .stop_mode(stop_mode), .wake_req(wake_req),
		.irq_req(irq_req), .irq(irq));
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd
	// two sync stages plus detect and flag: six edges leave margin
	task pr(input logic [7:0] p);
		@(posedge clk);
		press <= p;
		repeat (6) @(posedge clk);
	endtask : pr
	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			conclude();
		end
	end
	initial
	begin
		rst_b = 0;
		stop_mode = 0;
		clk_en = 1;
		press = 8'h00;
		req = '0;
		repeat (10) @(posedge clk);
		rst_b <= 1;
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h4, 8'h00);
		$display("test 1 done");
		// polarity before enable, else pin 4 idles asserted
		wr(4'h0, 8'h12);
		wr(4'h1, 8'h11);
		rd(4'h0, 8'h12);
		pr(8'h01);
		rd(4'h0, 8'h1a);
		chk({7'h0, irq_req}, 8'h01);
		wr(4'h0, 8'h16);
		rd(4'h0, 8'h12);
		chk({7'h0, irq_req}, 8'h00);
		pr(8'h00);
		rd(4'h0, 8'h12);
		pr(8'h10);
		rd(4'h0, 8'h1a);
		wr(4'h0, 8'h16);
		pr(8'h12);
		rd(4'h0, 8'h12);
		$display("test 2 done");
		wr(4'h0, 8'h13);
		rd(4'h0, 8'h1b);
		wr(4'h0, 8'h17);
		rd(4'h0, 8'h1b);
		pr(8'h00);
		wr(4'h0, 8'h17);
		rd(4'h0, 8'h13);
		wr(4'h0, 8'h10);
		pr(8'h01);
		rd(4'h0, 8'h18);
		chk({7'h0, irq_req}, 8'h00);
		$display("test 3 done");
		wr(4'h2, 8'h03);
		rd(4'h2, 8'h00);
		pr(8'h00);
		pr(8'h01);
		rd(4'h2, 8'h01);
		chk({7'h0, irq}, 8'h00);
		wr(4'h3, 8'h01);
		rd(4'h3, 8'h01);
		chk({7'h0, irq}, 8'h01);
		wr(4'h2, 8'h01);
		rd(4'h2, 8'h00);
		chk({7'h0, irq}, 8'h00);
		$display("test 4 done");
		// frozen: the press must wait for clk_en, and the mask write is dropped
		wr(4'h0, 8'h14);
		pr(8'h00);
		rd(4'h0, 8'h10);
		@(posedge clk);
		clk_en <= 0;
		pr(8'h01);
		wr(4'h3, 8'h00);
		@(posedge clk);
		clk_en <= 1;
		repeat (6) @(posedge clk);
		rd(4'h3, 8'h01);
		rd(4'h0, 8'h18);
		$display("test freeze done");
		@(posedge clk);
		stop_mode <= 1;
		repeat (3) @(posedge clk);
		#1 chk({7'h0, wake_req}, 8'h01);
		pr(8'h00);
		#1 chk({7'h0, wake_req}, 8'h00);
		$display("test 5 done");
		conclude();
	end
endmodule : keypad_pin_interrupt_tb
